// File: rtl/etr_recorder.v
// Execution trace recorder: AXI4-Lite registers, FIFO, SRAM arbiter
//
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/10ps
`include "etr_consts.vh"
module etr_recorder #(
   parameter AW = `ETR_SRAM_AW,
   parameter DEPTH = `ETR_FIFO_DEPTH,
   parameter [31:0] SRAM_BASE = `ETR_SRAM_BASE_RST
) (
   // Clock and reset
   input wire core_clk,
   input wire nrst,
   // AXI4-Lite write address
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_awaddr,
   // AXI4-Lite write data
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   // AXI4-Lite write response
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   output reg [1:0] s_axi_bresp,
   // AXI4-Lite read
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   input wire [31:0] s_axi_araddr,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   // Flow change reports from the core
   input wire flowValid,
   output wire flowReady,
   input wire [31:0] flowSrc,
   input wire [31:0] flowDst,
   // Processor port into the shared SRAM
   input wire cpuReq,
   input wire cpuWe,
   input wire [3:0] cpuBe,
   input wire [AW-1:0] cpuAddr,
   input wire [31:0] cpuWdata,
   output reg cpuAck_reg,
   // Shared SRAM command port
   output reg sramEn_reg,
   output reg sramWe_reg,
   output reg [3:0] sramBe_reg,
   output reg [AW-1:0] sramAddr_reg,
   output reg [31:0] sramWdata_reg,
   // Halt request to the core debug logic
   output reg haltReq_reg
);

   localparam PW = AW + 2;
   localparam QW = PW - 3;

   localparam ST_IDLE = 2'b00;
   localparam ST_WORD0 = 2'b01;
   localparam ST_WORD1 = 2'b10;

   // ==========================================================
   // Helpers
   function [31:0] mergeStrb;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] strb;
      integer b;
      begin
         mergeStrb = old;
         for (b = 0; b < 4; b = b + 1) begin
            if (strb[b]) begin
               mergeStrb[b*8 +: 8] = nw[b*8 +: 8];
            end
         end
      end
   endfunction

   // Packet-index bits that wrap inside a region of 2^(size+4) bytes
   function [QW-1:0] regionMask;
      input [4:0] size;
      integer i;
      begin
         regionMask = {QW{1'b0}};
         for (i = 0; i < QW; i = i + 1) begin
            regionMask[i] = (i <= {27'h0, size});
         end
      end
   endfunction

   function isOurPage;
      input [31:0] addr;
      begin
         isOurPage =
            (addr[`ETR_PAGE_HI:`ETR_PAGE_LO] == `ETR_BASE_PAGE);
      end
   endfunction

   // ==========================================================
   // Registers
   reg traceEn_reg;
   reg [4:0] regionSize_reg;
   reg [QW-1:0] ptr_reg;
   reg wrap_reg;
   reg [QW-1:0] watermark_reg;
   reg stopOnThreshold_reg;
   reg haltOnThreshold_reg;

   // ==========================================================
   // AXI4-Lite write path
   reg awHave_reg;
   reg wHave_reg;
   reg [31:0] awAddr_reg;
   reg [31:0] wData_reg;
   reg [3:0] wStrb_reg;
   wire doWrite;
   wire wrPosition;
   wire wrMaster;
   wire wrFlow;
   wire [11:0] wrOff;

   assign doWrite = awHave_reg && wHave_reg && !s_axi_bvalid;
   assign wrOff = awAddr_reg[11:0];
   assign wrPosition = doWrite && isOurPage(awAddr_reg) &&
      (wrOff == `ETR_OFF_POSITION);
   assign wrMaster = doWrite && isOurPage(awAddr_reg) &&
      (wrOff == `ETR_OFF_MASTER);
   assign wrFlow = doWrite && isOurPage(awAddr_reg) &&
      (wrOff == `ETR_OFF_FLOW);

   always @(posedge core_clk) begin
      if (!nrst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `ETR_RESP_OKAY;
         awHave_reg <= 1'b0;
         wHave_reg <= 1'b0;
         awAddr_reg <= 32'h00000000;
         wData_reg <= 32'h00000000;
         wStrb_reg <= 4'h0;
      end else begin
         // Address and data may arrive in either order
         if (s_axi_awvalid && s_axi_awready) begin
            awHave_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHave_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (doWrite) begin
            awHave_reg <= 1'b0;
            wHave_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // BASE is read only, so a write to it is refused too
            if (wrPosition || wrMaster || wrFlow) begin
               s_axi_bresp <= `ETR_RESP_OKAY;
            end else begin
               s_axi_bresp <= `ETR_RESP_SLVERR;
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // ==========================================================
   // AXI4-Lite read path
   wire [31:0] positionVal;
   wire [31:0] masterVal;
   wire [31:0] flowVal;
   wire [11:0] rdOff;

   assign positionVal = {{(32-PW){1'b0}}, ptr_reg, wrap_reg, 2'b00};
   assign masterVal = {traceEn_reg, 26'h0, regionSize_reg};
   assign flowVal = {{(32-PW){1'b0}}, watermark_reg, 1'b0,
      haltOnThreshold_reg, stopOnThreshold_reg};
   assign rdOff = s_axi_araddr[11:0];

   always @(posedge core_clk) begin
      if (!nrst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `ETR_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `ETR_RESP_OKAY;
            if (!isOurPage(s_axi_araddr)) begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `ETR_RESP_SLVERR;
            end else if (rdOff == `ETR_OFF_POSITION) begin
               s_axi_rdata <= positionVal;
            end else if (rdOff == `ETR_OFF_MASTER) begin
               s_axi_rdata <= masterVal;
            end else if (rdOff == `ETR_OFF_FLOW) begin
               s_axi_rdata <= flowVal;
            end else if (rdOff == `ETR_OFF_BASE) begin
               s_axi_rdata <= SRAM_BASE;
            end else begin
               // Only four registers exist in the page
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `ETR_RESP_SLVERR;
            end
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Report capture
   wire fifoInValid;
   wire fifoOutValid;
   wire fifoOutReady;
   wire [63:0] fifoOutData;

   // Reports seen while disabled are accepted and dropped
   assign fifoInValid = flowValid && traceEn_reg;

   etr_fifo #(
      .WIDTH(64),
      .DEPTH(DEPTH),
      .CW(5)
   ) u_fifo (
      .core_clk(core_clk),
      .nrst(nrst),
      .inValid(fifoInValid),
      .inReady_reg(flowReady),
      .inData({flowDst, flowSrc}),
      .outValid_reg(fifoOutValid),
      .outReady(fifoOutReady),
      .outData_reg(fifoOutData)
   );

   // ==========================================================
   // Packet writer and SRAM arbiter
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [63:0] pkt_reg;
   wire cpuSlot;
   wire [QW-1:0] regionBits;
   wire [QW-1:0] ptrInc;
   wire [QW-1:0] ptrAdv;
   wire wrapEvt;
   wire atMark;

   assign fifoOutReady = (state_reg == ST_IDLE);
   // Processor only gets idle cycles, and never right after an ack,
   // so a request still held high is not issued twice
   assign cpuSlot = (state_reg == ST_IDLE) && cpuReq &&
      !cpuAck_reg;

   assign regionBits = regionMask(regionSize_reg);
   assign ptrInc = ptr_reg + {{(QW-1){1'b0}}, 1'b1};
   // Upper bits fix the region start; low bits step and wrap
   assign ptrAdv = (ptr_reg & ~regionBits) |
      (ptrInc & regionBits);
   assign wrapEvt = ((ptrInc & regionBits) == {QW{1'b0}});
   assign atMark = (ptrAdv == watermark_reg);

   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (fifoOutValid) begin
               state_next = ST_WORD0;
            end
         end
         ST_WORD0: begin
            state_next = ST_WORD1;
         end
         ST_WORD1: begin
            state_next = ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always @(posedge core_clk) begin
      if (!nrst) begin
         state_reg <= ST_IDLE;
         pkt_reg <= 64'h0000000000000000;
         sramEn_reg <= 1'b0;
         sramWe_reg <= 1'b0;
         sramBe_reg <= 4'h0;
         sramAddr_reg <= {AW{1'b0}};
         sramWdata_reg <= 32'h00000000;
         cpuAck_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         sramEn_reg <= 1'b0;
         sramWe_reg <= 1'b0;
         cpuAck_reg <= 1'b0;
         if (state_reg == ST_IDLE && fifoOutValid) begin
            pkt_reg <= fifoOutData;
         end
         case (state_reg)
            ST_WORD0: begin
               sramEn_reg <= 1'b1;
               sramWe_reg <= 1'b1;
               sramBe_reg <= 4'hF;
               sramAddr_reg <= {ptr_reg, 1'b0};
               sramWdata_reg <= pkt_reg[31:0];
            end
            ST_WORD1: begin
               sramEn_reg <= 1'b1;
               sramWe_reg <= 1'b1;
               sramBe_reg <= 4'hF;
               sramAddr_reg <= {ptr_reg, 1'b1};
               sramWdata_reg <= pkt_reg[63:32];
            end
            default: begin
               if (cpuSlot) begin
                  sramEn_reg <= 1'b1;
                  sramWe_reg <= cpuWe;
                  sramBe_reg <= cpuBe;
                  sramAddr_reg <= cpuAddr;
                  sramWdata_reg <= cpuWdata;
                  cpuAck_reg <= 1'b1;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Control registers and pointer
   wire pktDone;
   wire [31:0] posMerged;
   wire [31:0] mstMerged;
   wire [31:0] flwMerged;

   assign pktDone = (state_reg == ST_WORD1);
   // Strobed write data merged over the current register image
   assign posMerged = mergeStrb(positionVal, wData_reg, wStrb_reg);
   assign mstMerged = mergeStrb(masterVal, wData_reg, wStrb_reg);
   assign flwMerged = mergeStrb(flowVal, wData_reg, wStrb_reg);

   always @(posedge core_clk) begin
      if (!nrst) begin
         traceEn_reg <= 1'b0;
         regionSize_reg <= `ETR_SIZE_RST;
         ptr_reg <= {QW{1'b0}};
         wrap_reg <= 1'b0;
         watermark_reg <= {QW{1'b0}};
         stopOnThreshold_reg <= 1'b0;
         haltOnThreshold_reg <= 1'b0;
         haltReq_reg <= 1'b0;
      end else begin
         haltReq_reg <= 1'b0;
         if (pktDone) begin
            ptr_reg <= ptrAdv;
            if (wrapEvt) begin
               wrap_reg <= 1'b1;
            end
            if (atMark && stopOnThreshold_reg) begin
               traceEn_reg <= 1'b0;
            end
            if (atMark && haltOnThreshold_reg) begin
               haltReq_reg <= 1'b1;
            end
         end
         if (wrPosition) begin
            ptr_reg <= posMerged[PW-1:`ETR_PTR_LO];
            // A wrap in the same cycle wins over a clear
            wrap_reg <= (pktDone && wrapEvt) ||
               posMerged[`ETR_WRAP_BIT];
         end
         if (wrMaster) begin
            // A direct write beats a simultaneous automatic stop
            traceEn_reg <= mstMerged[`ETR_EN_BIT];
            regionSize_reg <= mstMerged[`ETR_SIZE_HI:`ETR_SIZE_LO];
         end
         if (wrFlow) begin
            watermark_reg <= flwMerged[PW-1:`ETR_PTR_LO];
            stopOnThreshold_reg <= flwMerged[`ETR_STOP_BIT];
            haltOnThreshold_reg <= flwMerged[`ETR_HALT_BIT];
         end
      end
   end

endmodule

// File: rtl/etr_consts.vh
// Constants of the execution trace recorder: map, fields, resets, bus answers, sizes
`ifndef ETR_CONSTS_VH
`define ETR_CONSTS_VH

// ==========================================================
// Register map
`define ETR_BASE_ADDR 32'h41006000
`define ETR_PAGE_HI 31
`define ETR_PAGE_LO 12
`define ETR_BASE_PAGE 20'h41006
`define ETR_OFF_POSITION 12'h000
`define ETR_OFF_MASTER 12'h004
`define ETR_OFF_FLOW 12'h008
`define ETR_OFF_BASE 12'h00C

// ==========================================================
// Field positions
`define ETR_EN_BIT 31
`define ETR_SIZE_HI 4
`define ETR_SIZE_LO 0
`define ETR_WRAP_BIT 2
`define ETR_PTR_LO 3
`define ETR_STOP_BIT 0
`define ETR_HALT_BIT 1

// ==========================================================
// Reset values
`define ETR_SIZE_RST 5'h00
`define ETR_SRAM_BASE_RST 32'h20000000

// ==========================================================
// Bus answers, FIFO depth and SRAM address width
`define ETR_RESP_OKAY 2'h0
`define ETR_RESP_SLVERR 2'h2
`define ETR_FIFO_DEPTH 16
`define ETR_SRAM_AW 12

`endif

// File: rtl/etr_fifo.v
// Packet FIFO with registered read data and registered ready
`timescale 1ns/10ps
module etr_fifo #(
   parameter WIDTH = 64,
   parameter DEPTH = 16,
   parameter CW = 5
) (
   // Clock and reset
   input wire core_clk,
   input wire nrst,
   // Fill side
   input wire inValid,
   output reg inReady_reg,
   input wire [WIDTH-1:0] inData,
   // Drain side
   output reg outValid_reg,
   input wire outReady,
   output reg [WIDTH-1:0] outData_reg
);

   // ==========================================================
   // Storage
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [CW-2:0] wPtr_reg;
   reg [CW-2:0] rPtr_reg;
   reg [CW-1:0] cnt_reg;
   reg [CW-1:0] cnt_next;
   wire push;
   wire pop;

   assign push = inValid && inReady_reg;
   // Output register reloads from a non-empty store whenever it is empty or being drained
   assign pop = (cnt_reg != {CW{1'b0}}) && (!outValid_reg || outReady);

   always @* begin
      cnt_next = cnt_reg;
      if (push && !pop) begin
         cnt_next = cnt_reg + {{(CW-1){1'b0}}, 1'b1};
      end else if (pop && !push) begin
         cnt_next = cnt_reg - {{(CW-1){1'b0}}, 1'b1};
      end
   end

   always @(posedge core_clk) begin
      if (push) begin
         mem[wPtr_reg] <= inData;
      end
   end

   always @(posedge core_clk) begin
      if (!nrst) begin
         wPtr_reg <= {(CW-1){1'b0}};
         rPtr_reg <= {(CW-1){1'b0}};
         cnt_reg <= {CW{1'b0}};
         inReady_reg <= 1'b0;
         outValid_reg <= 1'b0;
         outData_reg <= {WIDTH{1'b0}};
      end else begin
         cnt_reg <= cnt_next;
         inReady_reg <= (cnt_next < DEPTH[CW-1:0]);
         if (push) begin
            wPtr_reg <= wPtr_reg + {{(CW-2){1'b0}}, 1'b1};
         end
         if (pop) begin
            outData_reg <= mem[rPtr_reg];
            rPtr_reg <= rPtr_reg + {{(CW-2){1'b0}}, 1'b1};
            outValid_reg <= 1'b1;
         end else if (outReady) begin
            outValid_reg <= 1'b0;
         end
      end
   end

endmodule

// File: verif/etr_sram_model.sv
// Shared SRAM model that records every write the recorder issues
`timescale 1ns/10ps
module etr_sram_model #(
   parameter AW = 12
) (
   // Clock
   input wire core_clk,
   // Command port
   input wire sramEn,
   input wire sramWe,
   input wire [3:0] sramBe,
   input wire [AW-1:0] sramAddr,
   input wire [31:0] sramWdata
);
   // ==========================================================
   // Storage
   // The bench peeks here the way a debug agent would read trace
   reg [31:0] mem [0:(1<<AW)-1];
   integer writeCount = 0;
   integer b;
   always @(posedge core_clk) begin
      if (sramEn && sramWe) begin
         writeCount <= writeCount + 1;
         for (b = 0; b < 4; b = b + 1) begin
            if (sramBe[b]) begin
               mem[sramAddr][8*b +: 8] <= sramWdata[8*b +: 8];
            end
         end
      end
   end
endmodule

// File: verif/etr_recorder_chk.sv
// Port-level checker for the execution trace recorder
`timescale 1ns/10ps
module etr_recorder_chk #(
   parameter AW = 12
) (
   // Clock and reset
   input wire core_clk,
   input wire nrst,
   // Register bus
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] s_axi_rdata,
   // Processor and SRAM side
   input wire cpuWe,
   input wire [AW-1:0] cpuAddr,
   input wire cpuAck_reg,
   input wire sramEn_reg,
   input wire sramWe_reg,
   input wire [AW-1:0] sramAddr_reg,
   input wire haltReq_reg
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // ==========================================================
   // Assertions
   a_cpu_grant_path: assert property (cpuAck_reg |-> sramEn_reg &&
      sramWe_reg == $past(cpuWe) && sramAddr_reg == $past(cpuAddr))
      else $error("cpu grant does not carry the cpu request");
   a_packet_pair: assert property (sramEn_reg && sramWe_reg &&
      !cpuAck_reg && !sramAddr_reg[0] |=> sramEn_reg && sramWe_reg &&
      !cpuAck_reg && sramAddr_reg == $past(sramAddr_reg) + 1'b1)
      else $error("trace packet second word missing or interrupted");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   a_write_busy: assert property (s_axi_bvalid
      |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   a_halt_pulse: assert property (haltReq_reg |-> sramEn_reg &&
      sramWe_reg && sramAddr_reg[0] ##1 !haltReq_reg)
      else $error("halt request not a single pulse on packet end");
endmodule

// File: verif/tb_top.sv
// Self-checking testbench for the execution trace recorder
`timescale 1ns/10ps
`include "etr_consts.vh"
module tb_top;
   localparam [31:0] A_POS = `ETR_BASE_ADDR + `ETR_OFF_POSITION;
   localparam [31:0] A_MST = `ETR_BASE_ADDR + `ETR_OFF_MASTER;
   localparam [31:0] A_FLW = `ETR_BASE_ADDR + `ETR_OFF_FLOW;
   localparam [31:0] A_BAS = `ETR_BASE_ADDR + `ETR_OFF_BASE;
   reg core_clk = 0, nrst = 0;
   reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   reg [31:0] awaddr = 0, wdata = 0, araddr = 0;
   reg [3:0] wstrb = 0;
   wire awready, wready, bvalid, arready, rvalid;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   reg flowValid = 0, cpuReq = 0, cpuWe = 0;
   reg [31:0] flowSrc = 0, flowDst = 0, cpuWdata = 0;
   reg [3:0] cpuBe = 0;
   reg [11:0] cpuAddr = 0;
   wire flowReady, cpuAck, sEn, sWe, haltReq;
   wire [3:0] sBe;
   wire [11:0] sAddr;
   wire [31:0] sWdata;
   integer miscompares = 0, numChecks = 0, cycles = 0, halts = 0, n0;

   etr_recorder DUT (.core_clk(core_clk), .nrst(nrst),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .flowValid(flowValid), .flowReady(flowReady),
      .flowSrc(flowSrc), .flowDst(flowDst), .cpuReq(cpuReq), .cpuWe(cpuWe),
      .cpuBe(cpuBe), .cpuAddr(cpuAddr), .cpuWdata(cpuWdata),
      .cpuAck_reg(cpuAck), .sramEn_reg(sEn), .sramWe_reg(sWe),
      .sramBe_reg(sBe), .sramAddr_reg(sAddr), .sramWdata_reg(sWdata),
      .haltReq_reg(haltReq));
   etr_sram_model sram (.core_clk(core_clk), .sramEn(sEn), .sramWe(sWe),
      .sramBe(sBe), .sramAddr(sAddr), .sramWdata(sWdata));

   // ==========================================================
   // Clock, timeout and shared tasks
   initial begin
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (haltReq === 1'b1) halts <= halts + 1;
      if (cycles == 20000) begin
         miscompares = miscompares + 1;
         conclude();
      end
   end
   task conclude;
      $display("checks %0d mismatches %0d", numChecks, miscompares);
      if (miscompares == 0 && numChecks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task check(input string what, input [31:0] seen, input [31:0] exp);
      numChecks = numChecks + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task axiWrite(input [31:0] a, input [31:0] d, input [1:0] er);
      reg done;
      done = 0;
      awaddr <= a; wdata <= d; wstrb <= 4'hF;
      awvalid <= 1; wvalid <= 1; bready <= 1;
      while (!done) begin
         @(posedge core_clk);
         if (awvalid && awready) awvalid <= 0;
         if (wvalid && wready) wvalid <= 0;
         if (bvalid) begin
            done = 1;
            check("bresp", bresp, er);
         end
      end
   endtask
   task axiRead(input [31:0] a, input [31:0] exp, input [1:0] er);
      reg done;
      done = 0;
      araddr <= a; arvalid <= 1; rready <= 1;
      while (!done) begin
         @(posedge core_clk);
         if (arvalid && arready) arvalid <= 0;
         if (rvalid) begin
            done = 1;
            check("rresp", rresp, er);
            check("rdata", rdata, exp);
         end
      end
   endtask
   // Reports carry src = base + 16*i and dst = src + 8
   task sendReports(input integer n, input [31:0] base);
      integer i;
      i = 0;
      flowSrc <= base; flowDst <= base + 8; flowValid <= 1;
      while (i < n) begin
         @(posedge core_clk);
         if (flowReady) begin
            i = i + 1;
            flowSrc <= base + 16 * i;
            flowDst <= base + 16 * i + 8;
            if (i == n) flowValid <= 0;
         end
      end
      repeat (20) @(posedge core_clk);
   endtask

   // ==========================================================
   // Scenarios
   task regResetAndMap;
      axiRead(A_POS, 32'h0, `ETR_RESP_OKAY);
      axiRead(A_MST, 32'h0, `ETR_RESP_OKAY);
      axiRead(A_FLW, 32'h0, `ETR_RESP_OKAY);
      axiRead(A_BAS, `ETR_SRAM_BASE_RST, `ETR_RESP_OKAY);
      axiRead(`ETR_BASE_ADDR + 32'h10, 32'h0, `ETR_RESP_SLVERR);
      axiWrite(A_BAS, 32'h0, `ETR_RESP_SLVERR);
      axiRead(A_BAS, `ETR_SRAM_BASE_RST, `ETR_RESP_OKAY);
   endtask
   task disabledDrop;
      n0 = sram.writeCount;
      sendReports(2, 32'h1000);
      check("writes off", sram.writeCount, n0);
   endtask
   task wrapSmallRegion;
      axiWrite(A_MST, 32'h80000000, `ETR_RESP_OKAY);
      sendReports(3, 32'h2000);
      check("w0", sram.mem[0], 32'h2020);
      check("w1", sram.mem[1], 32'h2028);
      check("w2", sram.mem[2], 32'h2010);
      check("w3", sram.mem[3], 32'h2018);
      axiRead(A_POS, 32'hC, `ETR_RESP_OKAY);
   endtask
   task watermarkStop;
      axiWrite(A_POS, 32'h28, `ETR_RESP_OKAY);
      axiWrite(A_MST, 32'h80000003, `ETR_RESP_OKAY);
      axiWrite(A_FLW, 32'h3B, `ETR_RESP_OKAY);
      sendReports(2, 32'h3000);
      check("start", sram.mem[10], 32'h3000);
      check("end", sram.mem[13], 32'h3018);
      axiRead(A_MST, 32'h3, `ETR_RESP_OKAY);
      axiRead(A_POS, 32'h38, `ETR_RESP_OKAY);
      check("halts", halts, 1);
      n0 = sram.writeCount;
      sendReports(1, 32'h3100);
      check("stopped", sram.writeCount, n0);
   endtask
   task cpuWhileTracing;
      axiWrite(A_FLW, 32'h0, `ETR_RESP_OKAY);
      axiWrite(A_POS, 32'h0, `ETR_RESP_OKAY);
      axiWrite(A_MST, 32'h80000003, `ETR_RESP_OKAY);
      n0 = sram.writeCount;
      fork
         sendReports(4, 32'h4000);
         begin
            cpuReq <= 1; cpuWe <= 1; cpuBe <= 4'hF;
            cpuAddr <= 12'h100; cpuWdata <= 32'hCAFE0001;
            @(posedge core_clk);
            while (cpuAck !== 1'b1) @(posedge core_clk);
            cpuReq <= 0;
         end
      join
      check("cpu data", sram.mem[12'h100], 32'hCAFE0001);
      check("last src", sram.mem[6], 32'h4030);
      check("last dst", sram.mem[7], 32'h4038);
      check("writes", sram.writeCount - n0, 9);
   endtask

   initial begin
      repeat (5) @(posedge core_clk);
      nrst <= 1;
      @(posedge core_clk);
      regResetAndMap();
      disabledDrop();
      wrapSmallRegion();
      watermarkStop();
      cpuWhileTracing();
      conclude();
   end
endmodule

bind etr_recorder etr_recorder_chk #(.AW(AW)) chk (.core_clk(core_clk),
   .nrst(nrst), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata), .cpuWe(cpuWe), .cpuAddr(cpuAddr),
   .cpuAck_reg(cpuAck_reg), .sramEn_reg(sramEn_reg),
   .sramWe_reg(sramWe_reg), .sramAddr_reg(sramAddr_reg),
   .haltReq_reg(haltReq_reg));
